// ==== pms_holdover_avg.sv ====
// Holdover frequency history and windowed average
`timescale 1ns/1ns
`default_nettype none
`include "pms_map.svh"
module pms_holdover_avg
    import pms_pkg::*;
#(
    parameter int SAMPLE_CYC = `PMS_SAMPLE_CYC
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_b,
    input  wire logic                       i_record,
    input  wire logic [`PMS_FREQ_W-1:0]     i_freq,
    input  wire logic [`PMS_WIN_W-1:0]      i_win,
    input  wire logic [`PMS_WIN_W-1:0]      i_delay,
    input  wire logic                       i_calc,
    output logic                            o_busy,
    output logic [`PMS_FREQ_W-1:0]          o_avg
);
    logic [`PMS_FREQ_W-1:0]     hist [`PMS_HIST_DEPTH];
    logic [`PMS_HIST_AW-1:0]    wr_ptr;
    logic [`PMS_HIST_AW:0]      fill;
    logic [31:0]                tick;
    logic [`PMS_HIST_AW-1:0]    rd_ptr;
    logic [`PMS_WIN_W-1:0]      left;
    logic [`PMS_WIN_W:0]        used;
    logic [`PMS_FREQ_W+`PMS_WIN_W-1:0] acc;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || !i_record) begin
            tick <= 32'h0;
        end else if (tick == 32'(SAMPLE_CYC - 1)) begin
            tick <= 32'h0;
        end else begin
            tick <= tick + 32'h1;
        end
    end

    // One sample per second keeps the last 120 seconds while locked
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            wr_ptr <= '0;
            fill   <= '0;
        end else if (i_record && tick == 32'(SAMPLE_CYC - 1)) begin
            hist[wr_ptr] <= i_freq;
            wr_ptr       <= wr_ptr + 1'b1;
            if (fill < (`PMS_HIST_AW+1)'(`PMS_HIST_SEC)) begin
                fill <= fill + 1'b1;
            end
        end
    end

    // Skip the newest samples by the delay, then average the window
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_busy <= 1'b0;
            rd_ptr <= '0;
            left   <= '0;
            used   <= '0;
            acc    <= '0;
            o_avg  <= '0;
        end else if (i_calc && !o_busy) begin
            o_busy <= 1'b1;
            rd_ptr <= wr_ptr - 1'b1 - i_delay;
            left   <= (i_win == '0) ? `PMS_WIN_W'(1) : i_win;
            used   <= '0;
            acc    <= '0;
        end else if (o_busy) begin
            if (left != '0 && (`PMS_HIST_AW+1)'(used) + (`PMS_HIST_AW+1)'(i_delay) < fill) begin
                acc    <= acc + (`PMS_FREQ_W+`PMS_WIN_W)'(hist[rd_ptr]);
                rd_ptr <= rd_ptr - 1'b1;
                left   <= left - 1'b1;
                used   <= used + 1'b1;
            end else begin
                o_busy <= 1'b0;
                // An empty history leaves the last average in place
                if (used != '0) begin
                    o_avg <= `PMS_FREQ_W'(acc / (`PMS_FREQ_W+`PMS_WIN_W)'(used));
                end
            end
        end
    end
endmodule : pms_holdover_avg
`default_nettype wire

// ==== pms_map.svh ====
// Constants for the PLL mode sequencer: field widths, codes and timing counts
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH

`define PMS_CLK_MHZ             100
`define PMS_NVM_WORDS           16
`define PMS_NVM_AW              4
`define PMS_CFG_W               16
`define PMS_FREQ_W              32
`define PMS_STEP_W              16
`define PMS_NSYNTH              4
`define PMS_NIN                 4
`define PMS_HIST_DEPTH          128
`define PMS_HIST_AW             7
`define PMS_HIST_SEC            120
`define PMS_SAMPLE_MS           1000
`define PMS_SAMPLE_CYC          (`PMS_SAMPLE_MS * 1000 * `PMS_CLK_MHZ)
`define PMS_WIN_W               7
`define PMS_RAMP_SEL_W          6
`define PMS_RAMP_NSEL           42
`define PMS_RAMP_MIN_MPPM       200
`define PMS_RAMP_MAX_MPPM       40000000
`define PMS_BW_SEL_W            4
`define PMS_FAST_BW_MIN_HZ      100
`define PMS_FAST_BW_MAX_HZ      4000
`define PMS_PRESCALE_W          3
`define PMS_REF_DIRECT_MAX_MHZ  54
`define PMS_LOCK_CYC            1000
`define PMS_RAMP_TICK_CYC       100

`endif

// ==== pms_mode_sequencer.sv ====
// PLL mode sequencer: init, resets, mode machine, holdover, ramp, reference and stepping
`timescale 1ns/1ns
`default_nettype none
`include "pms_map.svh"
module pms_mode_sequencer
    import pms_pkg::*;
#(
    parameter int SAMPLE_CYC = `PMS_SAMPLE_CYC
) (
    input  wire logic                           i_clk,
    input  wire logic                           i_rst_b,
    input  wire logic                           i_hard_reset_n_pin,
    input  wire logic                           i_hard_reset_bit,
    input  wire logic                           i_soft_reset,
    output logic [`PMS_NVM_AW-1:0]              o_nvm_addr,
    output logic                                o_nvm_rd,
    input  wire logic [`PMS_CFG_W-1:0]          i_nvm_data,
    input  wire logic [`PMS_CFG_W-1:0]          i_cfg_wdata,
    input  wire logic [`PMS_NVM_AW-1:0]         i_cfg_waddr,
    input  wire logic                           i_cfg_we,
    output logic                                o_serial_ready,
    output logic                                o_out_enable,
    input  wire logic [`PMS_NIN-1:0]            i_in_valid,
    input  wire logic [1:0]                     i_in_sel,
    input  wire logic                           i_fast_lock_en,
    input  wire logic [`PMS_BW_SEL_W-1:0]       i_fast_bw_sel,
    input  wire logic [`PMS_BW_SEL_W-1:0]       i_loop_bw_sel,
    input  wire logic [`PMS_BW_SEL_W-1:0]       i_exit_bw_sel,
    input  wire logic                           i_exit_bw_en,
    input  wire logic                           i_ramp_exit_en,
    input  wire logic [`PMS_RAMP_SEL_W-1:0]     i_ramp_sel,
    input  wire logic                           i_phase_locked,
    input  wire logic [`PMS_FREQ_W-1:0]         i_input_freq,
    input  wire logic [`PMS_WIN_W-1:0]          i_hold_win,
    input  wire logic [`PMS_WIN_W-1:0]          i_hold_delay,
    input  wire logic                           i_freq_step_up,
    input  wire logic                           i_freq_step_down,
    input  wire logic                           i_freq_step_up_reg,
    input  wire logic                           i_freq_step_down_reg,
    input  wire logic [`PMS_STEP_W-1:0]         i_freq_step_word,
    input  wire logic [`PMS_NSYNTH-1:0]         i_synth_step_mask,
    output logic [1:0]                          o_mode,
    output logic                                o_lock_lost_indicator,
    output logic                                o_lock_status,
    output logic                                o_ref_from_input,
    output logic [`PMS_BW_SEL_W-1:0]            o_bw_sel,
    output logic                                o_ramp_active,
    output logic [`PMS_FREQ_W-1:0]              o_target_freq,
    output logic [`PMS_FREQ_W-1:0]              o_hold_freq,
    output logic                                o_external_ref_mode,
    output logic                                o_load_caps_en,
    output logic [`PMS_PRESCALE_W-1:0]          o_ref_prescale_divider,
    output logic [`PMS_STEP_W+7:0]              o_synth_offset [`PMS_NSYNTH]
);
    // Config word 0: bit0 external ref, bits 3:1 prescaler; other words are kept in the shadow only
    logic [`PMS_CFG_W-1:0]  shadow [`PMS_NVM_WORDS];
    logic [`PMS_CFG_W-1:0]  active_cfg0;
    logic [2:0]             rst_sync;
    logic [2:0]             up_sync;
    logic [2:0]             dn_sync;
    logic                   hard_req;
    logic                   soft_d;
    pms_init_t              init_st;
    logic [`PMS_NVM_AW:0]   load_idx;
    logic                   load_pend;
    pms_mode_t              mode;
    pms_mode_t              next_mode;
    logic [15:0]            lock_cnt;
    logic                   sel_valid;
    logic                   any_valid;
    logic                   hold_calc;
    logic                   hold_busy;
    logic                   from_hold;
    logic [`PMS_FREQ_W-1:0] ramp_freq;
    logic [`PMS_FREQ_W-1:0] ramp_step;
    logic [7:0]             ramp_tick;
    logic                   step_up_ev;
    logic                   step_dn_ev;

    // Rate code 0 is 0.2 ppm/s doubling about every 3 codes up to 2457.6 ppm/s at code 41
    function automatic logic [`PMS_FREQ_W-1:0] ramp_rate(input logic [`PMS_RAMP_SEL_W-1:0] sel);
        logic [`PMS_RAMP_SEL_W-1:0] s;
        s = (sel >= `PMS_RAMP_SEL_W'(`PMS_RAMP_NSEL)) ? `PMS_RAMP_SEL_W'(`PMS_RAMP_NSEL - 1) : sel;
        return `PMS_FREQ_W'((64'(`PMS_RAMP_MIN_MPPM) << (s / 3)) * (64'(4) + 64'(s % 3)) / 64'(4));
    endfunction : ramp_rate

    function automatic logic pulse(input logic [2:0] sync);
        return sync[1] & ~sync[2];
    endfunction : pulse

    // Pins are off-domain: two flops before use, third only for edge detect
    always_ff @(posedge i_clk) begin
        rst_sync <= {rst_sync[1:0], i_hard_reset_n_pin};
        up_sync  <= {up_sync[1:0], i_freq_step_up};
        dn_sync  <= {dn_sync[1:0], i_freq_step_down};
    end

    assign hard_req = !rst_sync[1] || i_hard_reset_bit;

    // Initialization: copy NVM into the shadow, then release serial access
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || hard_req) begin
            init_st   <= PMS_INIT_IDLE;
            load_idx  <= '0;
            load_pend <= 1'b0;
        end else begin
            unique case (init_st)
                PMS_INIT_IDLE: init_st <= PMS_INIT_LOAD;
                PMS_INIT_LOAD: begin
                    load_pend <= 1'b1;
                    if (load_pend) begin
                        load_idx <= load_idx + 1'b1;
                    end
                    if (load_idx == (`PMS_NVM_AW+1)'(`PMS_NVM_WORDS - 1) && load_pend) begin
                        init_st <= PMS_INIT_DONE;
                    end
                end
                PMS_INIT_DONE: init_st <= PMS_INIT_DONE;
                default:       init_st <= PMS_INIT_IDLE;
            endcase
        end
    end

    assign o_nvm_rd       = (init_st == PMS_INIT_LOAD);
    assign o_nvm_addr     = load_pend ? `PMS_NVM_AW'(load_idx + 1'b1) : '0;
    assign o_serial_ready = (init_st == PMS_INIT_DONE);

    // Write at the address being read; the last load cycle wraps to word 0 and rewrites the same value
    always_ff @(posedge i_clk) begin
        if (init_st == PMS_INIT_LOAD) begin
            shadow[o_nvm_addr] <= i_nvm_data;
        end else if (o_serial_ready && i_cfg_we) begin
            shadow[i_cfg_waddr] <= i_cfg_wdata;
        end
    end

    // Register writes stay pending until a soft reset applies them; the end of init applies NVM word 0 instead
    always_ff @(posedge i_clk) begin
        soft_d <= i_soft_reset;
        if (!i_rst_b || hard_req) begin
            active_cfg0 <= '0;
        end else if ((init_st == PMS_INIT_LOAD && load_idx == (`PMS_NVM_AW+1)'(`PMS_NVM_WORDS - 1) && load_pend)
                     || (o_serial_ready && i_soft_reset && !soft_d)) begin
            active_cfg0 <= shadow[0];
        end
    end

    assign o_external_ref_mode    = active_cfg0[0];
    assign o_load_caps_en         = o_serial_ready && !active_cfg0[0];
    assign o_ref_prescale_divider = active_cfg0[3:1];
    assign o_out_enable           = o_serial_ready;

    assign sel_valid = i_in_valid[i_in_sel];
    assign any_valid = |i_in_valid;

    // Mode machine; loss of the selected input keeps lock while any other input is valid
    always_comb begin
        next_mode = mode;
        unique case (mode)
            PMS_FREERUN: if (any_valid) next_mode = PMS_ACQUIRE;
            PMS_ACQUIRE: begin
                if (!any_valid) begin
                    next_mode = from_hold ? PMS_HOLDOVER : PMS_FREERUN;
                end else if (lock_cnt == 16'(`PMS_LOCK_CYC) && !o_ramp_active) begin
                    next_mode = PMS_LOCKED;
                end
            end
            PMS_LOCKED:   if (!sel_valid && !any_valid) next_mode = PMS_HOLDOVER;
            PMS_HOLDOVER: if (any_valid && !hold_busy) next_mode = PMS_ACQUIRE;
            default:      next_mode = PMS_FREERUN;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || !o_serial_ready) begin
            mode <= PMS_FREERUN;
        end else begin
            mode <= next_mode;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || mode != PMS_ACQUIRE || !i_phase_locked) begin
            lock_cnt <= '0;
        end else if (lock_cnt != 16'(`PMS_LOCK_CYC)) begin
            lock_cnt <= lock_cnt + 16'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || mode == PMS_FREERUN) begin
            from_hold <= 1'b0;
        end else if (mode == PMS_HOLDOVER) begin
            from_hold <= 1'b1;
        end else if (mode == PMS_LOCKED) begin
            from_hold <= 1'b0;
        end
    end

    assign o_mode                = mode;
    assign o_lock_status         = (mode == PMS_LOCKED);
    assign o_lock_lost_indicator = (mode != PMS_LOCKED);
    assign o_ref_from_input      = (mode == PMS_ACQUIRE || mode == PMS_LOCKED);

    // Fast code below 100 Hz floor is clamped by the core; normal returns when locked
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_bw_sel <= '0;
        end else if (mode == PMS_ACQUIRE && from_hold && !i_ramp_exit_en && i_exit_bw_en) begin
            o_bw_sel <= i_exit_bw_sel;
        end else if (mode == PMS_ACQUIRE && i_fast_lock_en) begin
            o_bw_sel <= i_fast_bw_sel;
        end else begin
            o_bw_sel <= i_loop_bw_sel;
        end
    end

    assign hold_calc = (mode == PMS_LOCKED && next_mode == PMS_HOLDOVER);

    pms_holdover_avg #(
        .SAMPLE_CYC (SAMPLE_CYC)
    ) u_hold (
        .i_clk      (i_clk),
        .i_rst_b    (i_rst_b),
        .i_record   (mode == PMS_LOCKED),
        .i_freq     (i_input_freq),
        .i_win      (i_hold_win),
        .i_delay    (i_hold_delay),
        .i_calc     (hold_calc),
        .o_busy     (hold_busy),
        .o_avg      (o_hold_freq)
    );

    // Ramp from the holdover frequency to the new input at one shared rate
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_ramp_active <= 1'b0;
            ramp_freq     <= '0;
            ramp_step     <= '0;
            ramp_tick     <= '0;
        end else if (mode == PMS_HOLDOVER && next_mode == PMS_ACQUIRE && i_ramp_exit_en) begin
            o_ramp_active <= 1'b1;
            ramp_freq     <= o_hold_freq;
            ramp_step     <= ramp_rate(i_ramp_sel);
            ramp_tick     <= '0;
        end else if (o_ramp_active) begin
            ramp_tick <= (ramp_tick == 8'(`PMS_RAMP_TICK_CYC - 1)) ? 8'h0 : ramp_tick + 8'h1;
            if (ramp_tick == 8'(`PMS_RAMP_TICK_CYC - 1)) begin
                if (ramp_freq + ramp_step < i_input_freq && ramp_freq < i_input_freq) begin
                    ramp_freq <= ramp_freq + ramp_step;
                end else if (ramp_freq > i_input_freq + ramp_step) begin
                    ramp_freq <= ramp_freq - ramp_step;
                end else begin
                    ramp_freq     <= i_input_freq;
                    o_ramp_active <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        unique case (mode)
            PMS_HOLDOVER: o_target_freq = o_hold_freq;
            PMS_ACQUIRE:  o_target_freq = o_ramp_active ? ramp_freq : i_input_freq;
            PMS_LOCKED:   o_target_freq = i_input_freq;
            default:      o_target_freq = '0;
        endcase
    end

    // Stepping is ignored in acquisition and holdover so a step cannot bias the average
    assign step_up_ev = (pulse(up_sync) || i_freq_step_up_reg) && (mode == PMS_FREERUN || mode == PMS_LOCKED);
    assign step_dn_ev = (pulse(dn_sync) || i_freq_step_down_reg) && (mode == PMS_FREERUN || mode == PMS_LOCKED);

    for (genvar g = 0; g < `PMS_NSYNTH; g++) begin : g_synth
        always_ff @(posedge i_clk) begin
            if (!i_rst_b || !o_serial_ready) begin
                o_synth_offset[g] <= '0;
            end else if (i_synth_step_mask[g] && step_up_ev && !step_dn_ev) begin
                o_synth_offset[g] <= o_synth_offset[g] + (`PMS_STEP_W+8)'(i_freq_step_word);
            end else if (i_synth_step_mask[g] && step_dn_ev && !step_up_ev) begin
                o_synth_offset[g] <= o_synth_offset[g] - (`PMS_STEP_W+8)'(i_freq_step_word);
            end
        end
    end
endmodule : pms_mode_sequencer
`default_nettype wire

// ==== pms_mode_sequencer_chk.sv ====
// Port-level properties of the PLL mode sequencer
`timescale 1ns/1ns
`default_nettype none
`include "pms_map.svh"
module pms_chk
    import pms_pkg::*;
(
    input wire logic                    i_clk,
    input wire logic                    i_rst_b,
    input wire logic                    i_hard_reset_bit,
    input wire logic [`PMS_NIN-1:0]     i_in_valid,
    input wire logic                    i_freq_step_up_reg,
    input wire logic                    i_freq_step_down_reg,
    input wire logic [`PMS_STEP_W-1:0]  i_freq_step_word,
    input wire logic [`PMS_NSYNTH-1:0]  i_synth_step_mask,
    input wire logic                    o_serial_ready,
    input wire logic                    o_out_enable,
    input wire logic [1:0]              o_mode,
    input wire logic                    o_lock_lost_indicator,
    input wire logic                    o_lock_status,
    input wire logic                    o_ref_from_input,
    input wire logic [`PMS_STEP_W+7:0]  o_synth_offset [`PMS_NSYNTH]
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_fresh_valid;
        o_serial_ready && !i_hard_reset_bit && o_mode == PMS_FREERUN && i_in_valid != '0;
    endsequence
    a_out_follow_init: assert property (o_out_enable == o_serial_ready)
        else $error("output enable differs from init done");
    a_hard_bit_restart: assert property (i_hard_reset_bit |=> !o_serial_ready)
        else $error("hard reset bit left the block ready");
    a_acq_start: assert property (s_fresh_valid |=> o_mode == PMS_ACQUIRE)
        else $error("valid input did not start acquisition");
    a_lock_flags: assert property (o_lock_status == (o_mode == PMS_LOCKED) && o_lock_lost_indicator != o_lock_status)
        else $error("lock pin or status bit wrong");
    a_ref_source: assert property (o_ref_from_input == (o_mode == PMS_ACQUIRE || o_mode == PMS_LOCKED))
        else $error("reference source wrong for mode");
    a_hold_entry: assert property (o_mode == PMS_LOCKED && i_in_valid == '0 && !i_hard_reset_bit |=> o_mode == PMS_HOLDOVER)
        else $error("no holdover after input loss");
    a_step_add: assert property (o_mode == PMS_LOCKED && i_freq_step_up_reg && !i_freq_step_down_reg && i_synth_step_mask[0]
        && !i_hard_reset_bit |=> o_synth_offset[0] == $past(o_synth_offset[0]) + $past(i_freq_step_word))
        else $error("step up did not add step word");
    a_step_blocked: assert property ((o_mode == PMS_ACQUIRE || o_mode == PMS_HOLDOVER) && !i_hard_reset_bit
        |=> $stable(o_synth_offset[0]))
        else $error("offset stepped outside freerun or locked");
endmodule : pms_chk
`default_nettype wire

// ==== pms_pkg.sv ====
// Types shared by the PLL mode sequencer
package pms_pkg;
    typedef enum logic [1:0] {
        PMS_FREERUN  = 2'b00,
        PMS_ACQUIRE  = 2'b01,
        PMS_LOCKED   = 2'b11,
        PMS_HOLDOVER = 2'b10
    } pms_mode_t;

    typedef enum logic [1:0] {
        PMS_INIT_IDLE = 2'b00,
        PMS_INIT_LOAD = 2'b01,
        PMS_INIT_DONE = 2'b11
    } pms_init_t;

    typedef enum logic [1:0] {
        PMS_BW_NORMAL = 2'b00,
        PMS_BW_FAST   = 2'b01,
        PMS_BW_EXIT   = 2'b11
    } pms_bw_t;
endpackage : pms_pkg

// ==== pms_src_model.sv ====
// Model of the input clock source on the far side of the mode sequencer
`timescale 1ns/1ns
`default_nettype none
module pms_src_model #(
    parameter int LOCK_DLY = 20
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_present,
    input  wire logic        i_track,
    input  wire logic [31:0] i_freq,
    output logic             o_valid,
    output logic             o_phase_locked,
    output logic [31:0]      o_freq
);
    int cnt;
    always_ff @(posedge i_clk) begin
        o_valid        <= i_rst_b && i_present;
        // Phase lock only once the loop has steered onto this input for a while
        cnt            <= (o_valid && i_track) ? cnt + 1 : 0;
        o_phase_locked <= i_rst_b && cnt >= LOCK_DLY;
        // A dead input carries no frequency: toggle so nothing reads a stale word
        o_freq         <= !i_rst_b ? 32'h0 : (o_valid ? i_freq : ~o_freq);
    end
endmodule : pms_src_model
`default_nettype wire

// ==== pms_tb.sv ====
// Self-checking bench for the PLL mode sequencer with an input source model
`timescale 1ns/1ns
`default_nettype none
`include "pms_map.svh"
module tb import pms_pkg::*; ;
    logic i_clk = 1'b0, i_rst_b = 1'b0, i_hard_reset_n_pin = 1'b1, i_hard_reset_bit = 1'b0, i_soft_reset = 1'b0;
    logic i_cfg_we = 1'b0, i_fast_lock_en = 1'b1, i_exit_bw_en = 1'b0, i_ramp_exit_en = 1'b0, present = 1'b0;
    logic i_freq_step_up = 1'b0, i_freq_step_down = 1'b0, i_freq_step_up_reg = 1'b0, i_freq_step_down_reg = 1'b0;
    logic [3:0] i_cfg_waddr = 4'h0, i_fast_bw_sel = 4'h9, i_loop_bw_sel = 4'h2, i_exit_bw_sel = 4'h6;
    logic [3:0] i_synth_step_mask = 4'h1, o_nvm_addr, i_in_valid, o_bw_sel;
    logic [15:0] i_cfg_wdata = 16'h0, i_freq_step_word = 16'h0010, i_nvm_data;
    logic [6:0] i_hold_win = 7'h08, i_hold_delay = 7'h02;
    logic [5:0] i_ramp_sel = 6'h29;
    logic [31:0] src_freq = 32'h0012_3456, i_input_freq, o_target_freq, o_hold_freq;
    logic [2:0] o_ref_prescale_divider;
    logic [1:0] i_in_sel = 2'h0, o_mode;
    logic o_nvm_rd, o_serial_ready, o_out_enable, o_lock_lost_indicator, o_lock_status, o_ref_from_input;
    logic o_ramp_active, o_external_ref_mode, o_load_caps_en, src_valid, i_phase_locked;
    logic [`PMS_STEP_W+7:0] o_synth_offset [`PMS_NSYNTH];
    int bad_count = 0, tests_run = 0;
    always #5 i_clk = ~i_clk;
    // Word 0 selects the external reference with a prescale of 2
    assign i_nvm_data = (o_nvm_addr == 4'h0) ? 16'h0005 : 16'h0000;
    assign i_in_valid = {3'h0, src_valid};
    pms_mode_sequencer #(.SAMPLE_CYC(10)) dut (.i_clk, .i_rst_b, .i_hard_reset_n_pin, .i_hard_reset_bit, .i_soft_reset,
        .o_nvm_addr, .o_nvm_rd, .i_nvm_data, .i_cfg_wdata, .i_cfg_waddr, .i_cfg_we, .o_serial_ready, .o_out_enable,
        .i_in_valid, .i_in_sel, .i_fast_lock_en, .i_fast_bw_sel, .i_loop_bw_sel, .i_exit_bw_sel, .i_exit_bw_en,
        .i_ramp_exit_en, .i_ramp_sel, .i_phase_locked, .i_input_freq, .i_hold_win, .i_hold_delay, .i_freq_step_up,
        .i_freq_step_down, .i_freq_step_up_reg, .i_freq_step_down_reg, .i_freq_step_word, .i_synth_step_mask, .o_mode,
        .o_lock_lost_indicator, .o_lock_status, .o_ref_from_input, .o_bw_sel, .o_ramp_active, .o_target_freq,
        .o_hold_freq, .o_external_ref_mode, .o_load_caps_en, .o_ref_prescale_divider, .o_synth_offset);
    pms_src_model #(.LOCK_DLY(20)) src (.i_clk, .i_rst_b, .i_present(present), .i_track(o_ref_from_input),
        .i_freq(src_freq), .o_valid(src_valid), .o_phase_locked(i_phase_locked), .o_freq(i_input_freq));
    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic pulse(ref logic s, input int n);
        s = 1'b1;
        repeat (n) @(negedge i_clk);
        s = 1'b0;
        @(negedge i_clk);
    endtask : pulse
    task automatic wait_mode(input pms_mode_t m, input int lim);
        for (int n = 0; n < lim && o_mode !== m; n++)
            @(negedge i_clk);
    endtask : wait_mode
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    task automatic t_config();
        chk(o_serial_ready === 1'b0 && o_out_enable === 1'b0, "ready during init");
        repeat (25) @(negedge i_clk);
        chk(o_serial_ready === 1'b1 && o_out_enable === 1'b1 && o_mode === PMS_FREERUN, "not live");
        chk(o_external_ref_mode === 1'b1 && o_load_caps_en === 1'b0 && o_ref_prescale_divider === 3'h2, "cfg");
        pulse(i_cfg_we, 1);
        pulse(i_soft_reset, 1);
        @(negedge i_clk);
        chk(o_external_ref_mode === 1'b0 && o_load_caps_en === 1'b1 && o_serial_ready === 1'b1, "soft reset");
        pulse(i_hard_reset_bit, 1);
        chk(o_serial_ready === 1'b0, "hard reset bit");
        i_hard_reset_n_pin = 1'b0;
        repeat (4) @(negedge i_clk);
        i_hard_reset_n_pin = 1'b1;
        repeat (30) @(negedge i_clk);
        chk(o_external_ref_mode === 1'b1 && o_serial_ready === 1'b1, "reload after pin");
        $display("config test done");
    endtask : t_config
    task automatic t_lock();
        present = 1'b1;
        wait_mode(PMS_ACQUIRE, 5);
        // Bandwidth select is registered from the mode, so it trails the mode by one cycle
        @(negedge i_clk);
        chk(o_mode === PMS_ACQUIRE && o_bw_sel === i_fast_bw_sel && o_ref_from_input === 1'b1, "acquire");
        wait_mode(PMS_LOCKED, 1100);
        @(negedge i_clk);
        chk(o_mode === PMS_LOCKED && o_bw_sel === i_loop_bw_sel, "locked bandwidth");
        chk(o_lock_lost_indicator === 1'b0 && o_lock_status === 1'b1 && o_target_freq === src_freq, "lock");
        $display("lock test done");
    endtask : t_lock
    task automatic t_step();
        pulse(i_freq_step_up_reg, 1);
        chk(o_synth_offset[0] === 24'h000010 && o_synth_offset[1] === 24'h0, "step up");
        pulse(i_freq_step_up, 5);
        chk(o_synth_offset[0] === 24'h000020, "pin step up");
        pulse(i_freq_step_down_reg, 3);
        chk(o_synth_offset[0] === 24'hfffff0, "back to back down");
        i_synth_step_mask = 4'hf;
        i_freq_step_up_reg = 1'b1;
        i_freq_step_down_reg = 1'b1;
        @(negedge i_clk);
        i_freq_step_up_reg = 1'b0;
        i_freq_step_down_reg = 1'b0;
        chk(o_synth_offset[0] === 24'hfffff0 && o_synth_offset[3] === 24'h0, "up and down together");
        pulse(i_freq_step_down, 5);
        chk(o_synth_offset[0] === 24'hffffe0 && o_synth_offset[3] === 24'hfffff0, "group step");
        $display("step test done");
    endtask : t_step
    task automatic t_hold();
        repeat (300) @(negedge i_clk);
        i_ramp_exit_en = 1'b1;
        present = 1'b0;
        wait_mode(PMS_HOLDOVER, 5);
        for (int n = 0; n < 40 && o_hold_freq !== src_freq; n++)
            @(negedge i_clk);
        chk(o_mode === PMS_HOLDOVER && o_hold_freq === src_freq && o_target_freq === src_freq, "hold");
        pulse(i_freq_step_up_reg, 1);
        chk(o_synth_offset[0] === 24'hffffe0, "step in holdover");
        src_freq = 32'h0012_3457;
        present = 1'b1;
        wait_mode(PMS_ACQUIRE, 60);
        chk(o_mode === PMS_ACQUIRE && o_ramp_active === 1'b1, "ramped exit");
        wait_mode(PMS_LOCKED, 1500);
        chk(o_mode === PMS_LOCKED, "relock");
        i_ramp_exit_en = 1'b0;
        i_exit_bw_en = 1'b1;
        present = 1'b0;
        wait_mode(PMS_HOLDOVER, 5);
        present = 1'b1;
        wait_mode(PMS_ACQUIRE, 60);
        @(negedge i_clk);
        chk(o_bw_sel === i_exit_bw_sel && o_ramp_active === 1'b0, "exit bandwidth");
        $display("holdover test done");
    endtask : t_hold
    initial begin
        #150000;
        $display("[FAIL] %0t watchdog expired", $time);
        bad_count++;
        conclude();
    end
    initial begin
        repeat (3) @(negedge i_clk);
        i_rst_b = 1'b1;
        t_config();
        t_lock();
        t_step();
        t_hold();
        conclude();
    end
endmodule : tb
bind pms_mode_sequencer pms_chk u_chk (.i_clk, .i_rst_b, .i_hard_reset_bit, .i_in_valid, .i_freq_step_up_reg,
    .i_freq_step_down_reg, .i_freq_step_word, .i_synth_step_mask, .o_serial_ready, .o_out_enable, .o_mode,
    .o_lock_lost_indicator, .o_lock_status, .o_ref_from_input, .o_synth_offset);
`default_nettype wire
